// >>> rtl/wwd_defines.vh
// wwd_defines.vh: constants for the windowed watchdog register block
// assumes: included by the wwd design files; holds definitions only
`ifndef WWD_DEFINES_VH
`define WWD_DEFINES_VH

// register indices; byte address is four times the index
`define WWD_IDX_CTRL_A       10'h18c
`define WWD_IDX_CTRL_B       10'h18d
`define WWD_IDX_PSC_LOW      10'h18e
`define WWD_IDX_PSC_HIGH     10'h18f
`define WWD_IDX_TIMER_STAT   10'h190
`define WWD_IDX_IRQ_STATUS   10'h191
`define WWD_IDX_IRQ_MASK     10'h192

// control_a fields
`define WWD_SEN_BIT          0
`define WWD_PS_LSB           1
`define WWD_PS_MSB           5
// control_b fields
`define WWD_WIN_LSB          0
`define WWD_WIN_MSB          2
`define WWD_CS_LSB           4
`define WWD_CS_MSB           6
// timer status fields
`define WWD_TMR_LSB          3
`define WWD_TMR_MSB          7
`define WWD_ARMED_BIT        2
// interrupt status and mask fields
`define WWD_IRQ_TIMEOUT_BIT  0
`define WWD_IRQ_VIOL_BIT     1
`define WWD_IRQ_W            2

// reset values and fuse codes
`define WWD_PS_RESET         5'h0b
`define WWD_PS_MAX           5'h12
`define WWD_PS_MIN           5'h00
`define WWD_PERIOD_FUSE_OPEN 5'h1f
`define WWD_CLK_FUSE_OPEN    3'h7
`define WWD_WIN_FUSE_OPEN    3'h7
`define WWD_CS_RESET         3'h0
`define WWD_WIN_FULL         3'h7
`define WWD_SEN_RESET        1'b0
`define WWD_PSC_RESET        18'h00000
`define WWD_TMR_RESET        5'h00
`define WWD_TMR_LAST         5'h1f
`define WWD_MODE_ALWAYS      2'h3
`define WWD_MODE_AWAKE       2'h2
`define WWD_MODE_SOFT        2'h1
`define WWD_MODE_OFF         2'h0

// clock source codes
`define WWD_CS_LFOSC         3'h0
`define WWD_CS_MFOSC         3'h1
`define WWD_CS_SECONDARY_OSC          3'h2
`define WWD_CS_EXTERNAL_OSC        3'h3

// synchroniser depth for pin inputs
`define WWD_SYNC_STAGES      3

`endif

// >>> rtl/wwd_sync.v
// wwd_sync.v: three-flop synchroniser with agreement filter for pin levels
// assumes: inputs are asynchronous levels; one clock, synchronous reset
`timescale 1ns/1ns
`include "wwd_defines.vh"

module wwd_sync #(
	parameter WIDTH = 6
) (
	// clock and control
	input  wire             clk_i,
	input  wire             rst_i,
	input  wire             ce_i,
	// levels
	input  wire [WIDTH-1:0] async_i,
	output wire [WIDTH-1:0] level_o
);

	reg [WIDTH-1:0] meta_ff;
	reg [WIDTH-1:0] mid_ff;
	reg [WIDTH-1:0] last_ff;
	reg [WIDTH-1:0] level_ff;
	wire [WIDTH-1:0] nxt_level;

	// a change only counts once stages two and three agree
	assign nxt_level = (mid_ff & last_ff) | (level_ff & (mid_ff | last_ff));
	assign level_o   = level_ff;

	always @(posedge clk_i) begin
		if (rst_i) begin
			meta_ff  <= {WIDTH{1'b0}};
			mid_ff   <= {WIDTH{1'b0}};
			last_ff  <= {WIDTH{1'b0}};
			level_ff <= {WIDTH{1'b0}};
		end else if (ce_i) begin
			meta_ff  <= async_i;
			mid_ff   <= meta_ff;
			last_ff  <= mid_ff;
			level_ff <= nxt_level;
		end
	end

endmodule // wwd_sync

// >>> rtl/wwd_top.v
// wwd_top.v: windowed watchdog timer with its register file on Avalon-MM
// assumes: fuses are static while running; oscillators and sleep come from
// other domains; the clear instruction pulse is on clk_i
//
// Summary of operation
// - period code doubles prescale from 1:32 upward
// - codes above 10010 act as 1 ms
// - period resets to 01011 or fuse value
// - period field read-only unless fuse all ones
// - soft enable only counts in soft mode
// - clock pick selects one of four oscillators
// - open clock fuse resets clock pick to 000
// - clock pick read-only unless fuse is 111
// - window code sets open share in eighths
// - window field resets from window fuse
// - window field read-only unless fuse is 111
// - window opens at count (7 minus code) times 4
// - timer status bit 2 shows armed state
// - 18-bit prescaler count readable over three registers
// - unarmed clear in windowed mode is a violation
// - control writes and armed clears reset counter
// - violation resets device and clears violation flag
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ns
`include "wwd_defines.vh"

module wwd_top #(
	parameter PSC_W = 18,
	parameter TMR_W = 5
) (
	// clock and control
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        ce_i,
	// avalon-mm slave
	input  wire [11:0] address_i,
	input  wire        read_i,
	input  wire        write_i,
	input  wire [31:0] writedata_i,
	input  wire [3:0]  byteenable_i,
	output wire [31:0] readdata_o,
	output wire        waitrequest_o,
	// configuration fuses
	input  wire [1:0]  watchdog_mode_fuse_i,
	input  wire [4:0]  period_fuse_i,
	input  wire [2:0]  clock_fuse_i,
	input  wire [2:0]  window_fuse_i,
	// oscillators and device state, asynchronous
	input  wire        low_freq_osc_i,
	input  wire        mid_freq_osc_i,
	input  wire        secondary_osc_i,
	input  wire        external_osc_i,
	input  wire        sleep_i,
	input  wire        ost_run_i,
	// cpu side
	input  wire        watchdog_clear_instr_i,
	// results
	output wire        wdt_reset_o,
	output wire        window_violation_flag_clr_o,
	output wire        wake_o,
	output wire        irq_o
);

	// state codes for the time-out action
	localparam ST_RUN  = 2'b01;
	localparam ST_HOLD = 2'b10;

	reg  [31:0]      readdata_ff;
	reg              wait_ff;
	reg  [4:0]       period_sel_ff;
	reg              soft_enable_ff;
	reg  [2:0]       clock_pick_ff;
	reg  [2:0]       window_sel_ff;
	reg              armed_ff;
	reg  [PSC_W-1:0] psc_ff;
	reg  [TMR_W-1:0] window_count_ff;
	reg  [1:0]       mode_fuse_ff;
	reg              period_lock_ff;
	reg              clock_lock_ff;
	reg              window_lock_ff;
	reg  [1:0]       state_ff;
	reg              wdt_reset_ff;
	reg              wv_clr_ff;
	reg              wake_ff;
	reg  [`WWD_IRQ_W-1:0] irq_status_ff;
	reg  [`WWD_IRQ_W-1:0] irq_mask_ff;
	reg              irq_ff;
	reg              osc_prev_ff;
	reg              sleep_prev_ff;

	wire [5:0]       sync_level;
	wire             osc_level;
	wire             sleep_lvl;
	wire             ost_lvl;
	wire [9:0]       reg_idx;
	wire             access;
	wire             wr_take;
	wire             rd_take;
	wire             wr_lane0;
	wire             wr_ctrl;
	wire             enabled;
	wire             tick;
	wire             psc_wrap;
	wire             timeout;
	wire             win_open;
	wire             windowed;
	wire             clr_ok;
	wire             violation;
	wire             counter_clear;
	wire [4:0]       eff_ps;
	wire [PSC_W-1:0] psc_limit;
	reg  [31:0]      nxt_readdata;
	reg  [`WWD_IRQ_W-1:0] nxt_irq_status;
	reg  [1:0]       nxt_state;

	// effective prescale exponent: reserved codes fall back to the shortest
	function [4:0] eff_period;
		input [4:0] code;
		begin
			if (code > `WWD_PS_MAX)
				eff_period = `WWD_PS_MIN;
			else
				eff_period = code;
		end
	endfunction

	// window opening threshold in window_count units
	function [TMR_W-1:0] open_from;
		input [2:0] code;
		begin
			// closed span is (7 - code) steps of four counts; 111 opens at zero
			open_from = {~code, 2'b00};
		end
	endfunction

	wwd_sync #(
		.WIDTH (6)
	) u_sync (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.ce_i    (ce_i),
		.async_i ({ost_run_i, sleep_i, external_osc_i, secondary_osc_i,
			mid_freq_osc_i, low_freq_osc_i}),
		.level_o (sync_level)
	);

	// clock source pick; reserved codes stop the count rather than guess
	assign osc_level = (clock_pick_ff == `WWD_CS_LFOSC)  ? sync_level[0] :
		(clock_pick_ff == `WWD_CS_MFOSC)  ? sync_level[1] :
		(clock_pick_ff == `WWD_CS_SECONDARY_OSC)   ? sync_level[2] :
		(clock_pick_ff == `WWD_CS_EXTERNAL_OSC) ? sync_level[3] : 1'b0;
	assign sleep_lvl = sync_level[4];
	assign ost_lvl   = sync_level[5];
	assign tick      = osc_level & ~osc_prev_ff;

	// bus decode
	assign reg_idx  = address_i[11:2];
	assign access   = (read_i | write_i) & ~wait_ff;
	assign wr_take  = access & write_i;
	assign rd_take  = access & read_i;
	assign wr_lane0 = wr_take & byteenable_i[0];
	assign wr_ctrl  = wr_lane0 & ((reg_idx == `WWD_IDX_CTRL_A) |
		(reg_idx == `WWD_IDX_CTRL_B));

	// enable per mode fuse
	assign enabled = (mode_fuse_ff == `WWD_MODE_ALWAYS) |
		((mode_fuse_ff == `WWD_MODE_AWAKE) & ~sleep_lvl) |
		((mode_fuse_ff == `WWD_MODE_SOFT) & soft_enable_ff);

	// period and window
	assign eff_ps    = eff_period(period_sel_ff);
	assign psc_limit = (eff_ps == 5'h00) ? {PSC_W{1'b0}} :
		(({{(PSC_W-1){1'b0}}, 1'b1} << eff_ps) - {{(PSC_W-1){1'b0}}, 1'b1});
	assign psc_wrap  = tick & (psc_ff == psc_limit);
	assign timeout   = enabled & psc_wrap & (window_count_ff == `WWD_TMR_LAST);
	assign win_open  = (window_sel_ff == `WWD_WIN_FULL) |
		(window_count_ff >= open_from(window_sel_ff));
	assign windowed  = window_sel_ff != `WWD_WIN_FULL;

	// clear instruction checks
	assign clr_ok    = watchdog_clear_instr_i & (~windowed | (armed_ff & win_open));
	assign violation = enabled & watchdog_clear_instr_i & windowed &
		~(armed_ff & win_open);

	// sleep entry and exit, oscillator start-up and disable all clear the count
	assign counter_clear = wr_ctrl | clr_ok | ~enabled | ost_lvl |
		(sleep_lvl ^ sleep_prev_ff);

	// read mux
	always @* begin
		nxt_readdata = 32'h00000000;
		case (reg_idx)
			`WWD_IDX_CTRL_A: begin
				nxt_readdata[`WWD_PS_MSB:`WWD_PS_LSB] = period_sel_ff;
				nxt_readdata[`WWD_SEN_BIT]           = soft_enable_ff;
			end
			`WWD_IDX_CTRL_B: begin
				nxt_readdata[`WWD_CS_MSB:`WWD_CS_LSB]   = clock_pick_ff;
				nxt_readdata[`WWD_WIN_MSB:`WWD_WIN_LSB] = window_sel_ff;
			end
			`WWD_IDX_PSC_LOW: begin
				nxt_readdata[7:0] = psc_ff[7:0];
			end
			`WWD_IDX_PSC_HIGH: begin
				nxt_readdata[7:0] = psc_ff[15:8];
			end
			`WWD_IDX_TIMER_STAT: begin
				nxt_readdata[`WWD_TMR_MSB:`WWD_TMR_LSB] = window_count_ff;
				nxt_readdata[`WWD_ARMED_BIT]            = armed_ff;
				nxt_readdata[1:0]                       = psc_ff[17:16];
			end
			`WWD_IDX_IRQ_STATUS: begin
				nxt_readdata[`WWD_IRQ_W-1:0] = irq_status_ff;
			end
			`WWD_IDX_IRQ_MASK: begin
				nxt_readdata[`WWD_IRQ_W-1:0] = irq_mask_ff;
			end
			default: begin
				nxt_readdata = 32'h00000000;
			end
		endcase
	end

	// sticky events; a set in the clearing cycle survives
	always @* begin
		nxt_irq_status = irq_status_ff;
		if (wr_lane0 && (reg_idx == `WWD_IDX_IRQ_STATUS))
			nxt_irq_status = irq_status_ff & ~writedata_i[`WWD_IRQ_W-1:0];
		if (timeout)
			nxt_irq_status[`WWD_IRQ_TIMEOUT_BIT] = 1'b1;
		if (violation)
			nxt_irq_status[`WWD_IRQ_VIOL_BIT] = 1'b1;
	end

	// action state: hold after a reset request until the count is cleared
	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			ST_RUN: begin
				if ((timeout && !sleep_lvl) || violation)
					nxt_state = ST_HOLD;
			end
			ST_HOLD: begin
				if (counter_clear)
					nxt_state = ST_RUN;
			end
			default: begin
				nxt_state = ST_RUN;
			end
		endcase
	end

	// bus handshake: one wait cycle, then answer
	always @(posedge clk_i) begin
		if (rst_i) begin
			wait_ff     <= 1'b1;
			readdata_ff <= 32'h00000000;
		end else if (ce_i) begin
			wait_ff <= ~((read_i | write_i) & wait_ff);
			if (read_i && wait_ff)
				readdata_ff <= nxt_readdata;
		end
	end

	// control registers; fuses are caught on the reset cycle
	always @(posedge clk_i) begin
		if (rst_i) begin
			mode_fuse_ff   <= watchdog_mode_fuse_i;
			period_lock_ff <= period_fuse_i != `WWD_PERIOD_FUSE_OPEN;
			clock_lock_ff  <= clock_fuse_i != `WWD_CLK_FUSE_OPEN;
			window_lock_ff <= window_fuse_i != `WWD_WIN_FUSE_OPEN;
			period_sel_ff  <= (period_fuse_i == `WWD_PERIOD_FUSE_OPEN) ?
				`WWD_PS_RESET : period_fuse_i;
			soft_enable_ff <= `WWD_SEN_RESET;
			// locked clock pick has no defined value; 000 is used either way
			clock_pick_ff  <= `WWD_CS_RESET;
			window_sel_ff  <= window_fuse_i;
			irq_mask_ff    <= {`WWD_IRQ_W{1'b0}};
		end else if (ce_i) begin
			if (wr_lane0 && (reg_idx == `WWD_IDX_CTRL_A)) begin
				soft_enable_ff <= writedata_i[`WWD_SEN_BIT];
				if (!period_lock_ff)
					period_sel_ff <= writedata_i[`WWD_PS_MSB:`WWD_PS_LSB];
			end
			if (wr_lane0 && (reg_idx == `WWD_IDX_CTRL_B)) begin
				if (!clock_lock_ff)
					clock_pick_ff <= writedata_i[`WWD_CS_MSB:`WWD_CS_LSB];
				if (!window_lock_ff)
					window_sel_ff <= writedata_i[`WWD_WIN_MSB:`WWD_WIN_LSB];
			end
			if (wr_lane0 && (reg_idx == `WWD_IDX_IRQ_MASK))
				irq_mask_ff <= writedata_i[`WWD_IRQ_W-1:0];
		end
	end

	// arming: a read of control_a arms, any clear instruction disarms
	always @(posedge clk_i) begin
		if (rst_i) begin
			armed_ff <= 1'b0;
		end else if (ce_i) begin
			if (watchdog_clear_instr_i || !enabled)
				armed_ff <= 1'b0;
			else if (rd_take && (reg_idx == `WWD_IDX_CTRL_A))
				armed_ff <= 1'b1;
		end
	end

	// prescaler and window counter
	always @(posedge clk_i) begin
		if (rst_i) begin
			psc_ff          <= `WWD_PSC_RESET;
			window_count_ff <= `WWD_TMR_RESET;
			osc_prev_ff     <= 1'b0;
			sleep_prev_ff   <= 1'b0;
		end else if (ce_i) begin
			osc_prev_ff   <= osc_level;
			sleep_prev_ff <= sleep_lvl;
			if (counter_clear || state_ff == ST_HOLD) begin
				psc_ff          <= `WWD_PSC_RESET;
				window_count_ff <= `WWD_TMR_RESET;
			end else if (psc_wrap) begin
				psc_ff          <= `WWD_PSC_RESET;
				window_count_ff <= window_count_ff + {{(TMR_W-1){1'b0}}, 1'b1};
			end else if (tick) begin
				psc_ff <= psc_ff + {{(PSC_W-1){1'b0}}, 1'b1};
			end
		end
	end

	// outcomes; a time-out in sleep wakes instead of resetting
	always @(posedge clk_i) begin
		if (rst_i) begin
			state_ff      <= ST_RUN;
			wdt_reset_ff  <= 1'b0;
			wv_clr_ff     <= 1'b0;
			wake_ff       <= 1'b0;
			irq_status_ff <= {`WWD_IRQ_W{1'b0}};
			irq_ff        <= 1'b0;
		end else if (ce_i) begin
			state_ff      <= nxt_state;
			wdt_reset_ff  <= (state_ff == ST_RUN) &
				((timeout & ~sleep_lvl) | violation);
			wv_clr_ff     <= (state_ff == ST_RUN) & violation;
			wake_ff       <= timeout & sleep_lvl;
			irq_status_ff <= nxt_irq_status;
			irq_ff        <= |(nxt_irq_status & irq_mask_ff);
		end
	end

	assign readdata_o                  = readdata_ff;
	assign waitrequest_o               = wait_ff;
	assign wdt_reset_o                 = wdt_reset_ff;
	assign window_violation_flag_clr_o = wv_clr_ff;
	assign wake_o                      = wake_ff;
	assign irq_o                       = irq_ff;

endmodule // wwd_top

// >>> verif/wwd_top_asserts.sv
// wwd_top_asserts.sv: port checker for the watchdog register block
// assumes: bound into wwd_top; fuses change only while in reset
`timescale 1ns/1ns
module wwd_chk (
	// clock and bus
	input wire        clk_i,
	input wire        rst_i,
	input wire [11:0] address_i,
	input wire        read_i,
	input wire        write_i,
	input wire [31:0] readdata_o,
	input wire        waitrequest_o,
	// fuses and cpu
	input wire [1:0]  watchdog_mode_fuse_i,
	input wire [4:0]  period_fuse_i,
	input wire [2:0]  clock_fuse_i,
	input wire [2:0]  window_fuse_i,
	input wire        watchdog_clear_instr_i,
	// results
	input wire        wdt_reset_o,
	input wire        window_violation_flag_clr_o,
	input wire        wake_o,
	input wire        irq_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// answered read and its register index
	wire       rda = read_i & ~waitrequest_o;
	wire [9:0] idx = address_i[11:2];
	property p_wait_one;
		(read_i | write_i) & waitrequest_o |=> !waitrequest_o;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("bus not answered");
	property p_wait_pulse;
		!waitrequest_o |=> waitrequest_o;
	endproperty
	a_wait_pulse: assert property (p_wait_pulse) else $error("answer held too long");
	property p_hi_zero;
		readdata_o[31:8] == 24'h0;
	endproperty
	a_hi_zero: assert property (p_hi_zero) else $error("read data above byte");
	property p_ps_lock;
		rda && idx == 10'h18c && period_fuse_i != 5'h1f |-> readdata_o[5:1] == period_fuse_i;
	endproperty
	a_ps_lock: assert property (p_ps_lock) else $error("period not fuse value");
	property p_cs_lock;
		rda && idx == 10'h18d && clock_fuse_i != 3'h7 |-> readdata_o[6:4] == 3'h0;
	endproperty
	a_cs_lock: assert property (p_cs_lock) else $error("clock pick changed");
	property p_win_lock;
		rda && idx == 10'h18d && window_fuse_i != 3'h7 |-> readdata_o[2:0] == window_fuse_i;
	endproperty
	a_win_lock: assert property (p_win_lock) else $error("window not fuse value");
	property p_viol_rst;
		window_violation_flag_clr_o |-> wdt_reset_o;
	endproperty
	a_viol_rst: assert property (p_viol_rst) else $error("violation without reset");
	property p_viol_cause;
		window_violation_flag_clr_o |-> $past(watchdog_clear_instr_i);
	endproperty
	a_viol_cause: assert property (p_viol_cause) else $error("violation w/o clear");
	property p_one_pulse;
		wdt_reset_o |=> !wdt_reset_o;
	endproperty
	a_one_pulse: assert property (p_one_pulse) else $error("reset pulse too long");
	property p_mode_off;
		watchdog_mode_fuse_i == 2'h0 |-> !wdt_reset_o && !wake_o;
	endproperty
	a_mode_off: assert property (p_mode_off) else $error("reset while off");
	c_viol: cover property (window_violation_flag_clr_o);
	c_tout: cover property (wdt_reset_o && !window_violation_flag_clr_o);
	c_irq: cover property (irq_o);
endmodule // wwd_chk
bind wwd_top wwd_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .address_i(address_i),
	.read_i(read_i), .write_i(write_i), .readdata_o(readdata_o),
	.waitrequest_o(waitrequest_o), .watchdog_mode_fuse_i(watchdog_mode_fuse_i),
	.period_fuse_i(period_fuse_i), .clock_fuse_i(clock_fuse_i),
	.window_fuse_i(window_fuse_i), .watchdog_clear_instr_i(watchdog_clear_instr_i),
	.wdt_reset_o(wdt_reset_o), .window_violation_flag_clr_o(window_violation_flag_clr_o),
	.wake_o(wake_o), .irq_o(irq_o));

// >>> verif/wwd_top_test.sv
// wwd_top_test.sv: self-checking bench for the watchdog register block
// assumes: one 10 MHz clock; oscillators toggled slowly by the bench
`timescale 1ns/1ns
module wwd_top_test;
	reg         clk_i = 0;
	reg         rst_i = 1;
	reg         rd = 0;
	reg         wr = 0;
	reg         clr = 0;
	reg  [11:0] addr = 0;
	reg  [31:0] wd = 0;
	reg  [1:0]  mode = 2'h1;
	reg  [4:0]  pf = 5'h1f;
	reg  [2:0]  cf = 3'h7;
	reg  [2:0]  wf = 3'h7;
	reg  [3:0]  osc = 0;
	reg         slp = 0;
	reg         ce = 1;
	wire        wk;
	integer     nwake = 0;
	reg  [31:0] d;
	wire [31:0] rdat;
	wire        wreq;
	wire        wrst;
	wire        vclr;
	wire        irq;
	integer     fail_count = 0;
	integer     samples_checked = 0;
	integer     cyc = 0;
	integer     nrst = 0;
	integer     nviol = 0;
	integer     i;
	integer     n0;
	always #50 clk_i = ~clk_i;
	wwd_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .address_i(addr), .read_i(rd),
		.write_i(wr), .writedata_i(wd), .byteenable_i(4'hf), .readdata_o(rdat),
		.waitrequest_o(wreq), .watchdog_mode_fuse_i(mode), .period_fuse_i(pf),
		.clock_fuse_i(cf), .window_fuse_i(wf), .low_freq_osc_i(osc[0]),
		.mid_freq_osc_i(osc[1]), .secondary_osc_i(osc[2]), .external_osc_i(osc[3]),
		.sleep_i(slp), .ost_run_i(1'b0), .watchdog_clear_instr_i(clr), .wdt_reset_o(wrst),
		.window_violation_flag_clr_o(vclr), .wake_o(wk), .irq_o(irq));
	// pulse counters; the ceiling cuts a hang short
	always @(posedge clk_i) begin
		cyc = cyc + 1;
		if (wrst === 1'b1) nrst = nrst + 1;
		if (vclr === 1'b1) nviol = nviol + 1;
		if (wk === 1'b1) nwake = nwake + 1;
		if (cyc == 20000) begin
			fail_count = fail_count + 1;
			$display("mismatch at %0t: timeout", $time);
			summarize;
		end
	end
	task chk(input [31:0] got, input [31:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (got !== exp) begin
				fail_count = fail_count + 1;
				$display("mismatch at %0t: got %h want %h", $time, got, exp);
			end
		end
	endtask
	// one Avalon cycle; request held until waitrequest sampled low
	task bus(input w, input [9:0] x, input [7:0] v);
		integer n;
		begin
			@(posedge clk_i);
			rd <= !w;
			wr <= w;
			addr <= {x, 2'b00};
			wd <= {24'h0, v};
			n = 0;
			@(posedge clk_i);
			while (wreq !== 1'b0 && n < 20) begin
				@(posedge clk_i);
				n = n + 1;
			end
			chk({31'h0, wreq}, 32'h0);
			d = rdat;
			rd <= 1'b0;
			wr <= 1'b0;
		end
	endtask
	task rdc(input [9:0] x, input [7:0] e);
		begin
			bus(1'b0, x, 8'h0);
			chk(d, {24'h0, e});
		end
	endtask
	// ten cycles a tick, slow enough for the pin synchroniser
	task tick(input [1:0] s, input integer k);
		integer j;
		begin
			for (j = 0; j < k; j = j + 1) begin
				repeat (5) @(posedge clk_i);
				osc[s] <= 1'b1;
				repeat (5) @(posedge clk_i);
				osc[s] <= 1'b0;
			end
			repeat (8) @(posedge clk_i);
		end
	endtask
	task rst(input [1:0] m, input [4:0] p, input [2:0] c, input [2:0] w);
		begin
			@(posedge clk_i);
			rst_i <= 1'b1;
			mode <= m;
			pf <= p;
			cf <= c;
			wf <= w;
			repeat (12) @(posedge clk_i);
			rst_i <= 1'b0;
		end
	endtask
	task pulse;
		begin
			@(posedge clk_i);
			clr <= 1'b1;
			@(posedge clk_i);
			clr <= 1'b0;
			repeat (3) @(posedge clk_i);
		end
	endtask
	task t_reset;
		begin
			rst(2'h1, 5'h1f, 3'h7, 3'h7);
			rdc(10'h18c, 8'h16);
			rdc(10'h18d, 8'h07);
			rdc(10'h18e, 8'h00);
			rdc(10'h190, 8'h00);
			rdc(10'h193, 8'h00);
			$display("test reset done");
		end
	endtask
	task t_lock;
		begin
			rst(2'h3, 5'h05, 3'h2, 3'h3);
			bus(1'b1, 10'h18c, 8'hff);
			rdc(10'h18c, 8'h0b);
			bus(1'b1, 10'h18d, 8'hff);
			rdc(10'h18d, 8'h03);
			$display("test lock done");
		end
	endtask
	// code 0 and reserved 13 end after 32 ticks, code 1 after 64
	task t_period;
		begin
			rst(2'h1, 5'h1f, 3'h7, 3'h7);
			for (i = 0; i < 3; i = i + 1) begin
				bus(1'b1, 10'h18c, (i == 0) ? 8'h01 : (i == 1) ? 8'h03 : 8'h27);
				n0 = nrst;
				tick(2'd0, (i == 1) ? 63 : 31);
				chk(nrst - n0, 0);
				rdc(10'h18e, (i == 1) ? 8'h01 : 8'h00);
				rdc(10'h190, 8'hf8);
				tick(2'd0, 1);
				chk(nrst - n0, 1);
			end
			rdc(10'h191, 8'h01);
			chk({31'h0, irq}, 32'h0);
			bus(1'b1, 10'h192, 8'h01);
			repeat (2) @(posedge clk_i);
			chk({31'h0, irq}, 32'h1);
			bus(1'b1, 10'h191, 8'h01);
			repeat (2) @(posedge clk_i);
			chk({31'h0, irq}, 32'h0);
			$display("test period done");
		end
	endtask
	task t_soft;
		begin
			for (i = 0; i < 4; i = i + 1) begin
				rst(8'b10_11_00_01 >> (2 * i), 5'h1f, 3'h7, 3'h7);
				bus(1'b1, 10'h18c, {7'h0, 4'b0010 >> i});
				n0 = nrst;
				tick(2'd0, 32);
				chk(nrst - n0, (4'b1100 >> i) & 1);
			end
			$display("test enable done");
		end
	endtask
	task t_clock;
		begin
			rst(2'h1, 5'h1f, 3'h7, 3'h7);
			bus(1'b1, 10'h18c, 8'h01);
			for (i = 0; i < 5; i = i + 1) begin
				bus(1'b1, 10'h18d, {1'b0, i[2:0], 4'h7});
				tick(i[1:0] + 2'd1, 3);
				rdc(10'h190, 8'h00);
				tick(i[1:0], 3);
				rdc(10'h190, (i < 4) ? 8'h18 : 8'h00);
			end
			$display("test clock done");
		end
	endtask
	// window 110 opens at count 4
	task t_window;
		begin
			rst(2'h1, 5'h1f, 3'h7, 3'h7);
			bus(1'b1, 10'h18c, 8'h01);
			bus(1'b1, 10'h18d, 8'h06);
			n0 = nviol;
			pulse;
			chk(nviol - n0, 1);
			bus(1'b1, 10'h18d, 8'h06);
			tick(2'd0, 3);
			rdc(10'h18c, 8'h01);
			rdc(10'h190, 8'h1c);
			pulse;
			chk(nviol - n0, 2);
			bus(1'b1, 10'h18d, 8'h06);
			tick(2'd0, 4);
			rdc(10'h190, 8'h20);
			bus(1'b1, 10'h18c, 8'h01);
			rdc(10'h18c, 8'h01);
			rdc(10'h190, 8'h04);
			tick(2'd0, 4);
			pulse;
			chk(nviol - n0, 2);
			rdc(10'h190, 8'h00);
			$display("test window done");
		end
	endtask
	// time-out in sleep wakes instead of resetting; low enable freezes the count
	task t_sleep;
		begin
			rst(2'h3, 5'h1f, 3'h7, 3'h7);
			bus(1'b1, 10'h18c, 8'h01);
			slp <= 1'b1;
			n0 = nrst;
			tick(2'd0, 4);
			rdc(10'h190, 8'h20);
			tick(2'd0, 28);
			chk(nwake, 1);
			chk(nrst - n0, 0);
			ce <= 1'b0;
			tick(2'd0, 4);
			ce <= 1'b1;
			rdc(10'h190, 8'h00);
			slp <= 1'b0;
			$display("test sleep done");
		end
	endtask
	task summarize;
		begin
			$display("checked %0d mismatches %0d", samples_checked, fail_count);
			if (fail_count == 0 && samples_checked > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	initial begin
		t_reset;
		t_lock;
		t_period;
		t_soft;
		t_clock;
		t_window;
		t_sleep;
		summarize;
	end
endmodule // wwd_top_test
